/* File: bfc_host.sv */
// Host controller driving a boot flash through its parallel pins
//
// What this block does
// - Each command cycle has reset high, chip select and write strobe low, output enable high, code on the low lanes.
// - A block erase is an erase-setup 20H cycle directly followed by a D0H confirm with the program supply valid.
// - A program is a setup cycle of 40H directly followed by the address and data cycle.
// - After a program or erase the host writes read-array FFH before reading array data again.
// - Identification reads hold all address lines low except bit 0, which picks maker or device code.
`timescale 1ns/100ps
module bfc_host (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// User request port
	input  wire logic        op_valid,
	output logic             op_ready,
	input  wire logic [2:0]  op_code,
	input  wire logic [17:0] op_addr,
	input  wire logic [15:0] op_wdata,
	input  wire logic        op_boot,
	input  wire logic        byte_mode,
	// User answer port
	output logic             rsp_valid,
	output logic [15:0]      rsp_rdata,
	output logic             rsp_err,
	// Supply and protection controls
	input  wire logic        program_supply_level,
	output logic             program_supply_en,
	output logic             boot_unlock,
	output logic             identify_high_voltage,
	// Flash pins
	output logic             reset_powerdown_n,
	output logic             ce_n,
	output logic             oe_n,
	output logic             we_n,
	output logic             byte_n,
	output logic [16:0]      addr_o,
	output logic [15:0]      dq_o,
	output logic [15:0]      dq_oe,
	input  wire logic [15:0] dq_i
);
	typedef enum logic [5:0] {
		HS_IDLE  = 6'b000001,
		HS_CMD1  = 6'b000010,
		HS_CMD2  = 6'b000100,
		HS_RARR  = 6'b001000,
		HS_READ  = 6'b010000,
		HS_RESP  = 6'b100000
	} bfc_host_e;

	bfc_cyc_if cyc ();

	bfc_host_e   st_r;
	logic [2:0]  op_r;
	logic [17:0] addr_r;
	logic [15:0] wdata_r;
	logic        boot_r;
	logic        dirty_r;
	logic        err_r;
	logic [15:0] rdata_r;
	logic        supply_q1_r;
	logic        supply_q2_r;
	logic        supply_q3_r;
	logic        supply_ok_r;
	logic        issue_r;

	// Pin engine runs each single bus cycle
	bfc_cycle_engine u_eng (
		.mclk      (mclk),
		.nrst      (nrst),
		.cyc       (cyc.eng),
		.byte_mode (byte_mode),
		.ce_n      (ce_n),
		.oe_n      (oe_n),
		.we_n      (we_n),
		.addr_o    (addr_o),
		.dq_o      (dq_o),
		.dq_oe     (dq_oe),
		.dq_i      (dq_i)
	);

	// Supply-good level is a pin from outside; accept a change only when two stages agree
	always_ff @(posedge mclk) begin
		supply_q1_r <= program_supply_level;
		supply_q2_r <= supply_q1_r;
		supply_q3_r <= supply_q2_r;
		if (!nrst)
			supply_ok_r <= 1'b0;
		else if (supply_q2_r == supply_q3_r)
			supply_ok_r <= supply_q3_r;
	end

	// Flash reset follows our own reset; flash sits in array read afterwards
	always_ff @(posedge mclk) begin
		if (!nrst)
			reset_powerdown_n <= 1'b0;
		else
			reset_powerdown_n <= 1'b1;
	end

	// Request sequencer; commands always go out as back-to-back write cycles
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_r    <= HS_IDLE;
			op_r    <= bfc_pkg::OP_READ;
			addr_r  <= 18'h00000;
			wdata_r <= 16'h0000;
			boot_r  <= 1'b0;
			err_r   <= 1'b0;
			issue_r <= 1'b0;
		end else begin
			issue_r <= 1'b0;
			case (st_r)
				HS_IDLE: begin
					if (op_valid) begin
						op_r    <= op_code;
						// Identification reads keep every address bit low except word bit 0 (byte bit 1)
						addr_r  <= (op_code == bfc_pkg::OP_ID_READ) ?
							(op_addr[1] ? bfc_pkg::ID_DEVICE_ADDR : bfc_pkg::ID_MAKER_ADDR) : op_addr;
						wdata_r <= op_wdata;
						boot_r  <= op_boot;
						err_r   <= 1'b0;
						issue_r <= 1'b1;
						if (op_code == bfc_pkg::OP_PROGRAM || op_code == bfc_pkg::OP_ERASE ||
							op_code == bfc_pkg::OP_IDENTIFY)
							st_r <= HS_CMD1;
						else if (op_code == bfc_pkg::OP_READ_ARR)
							st_r <= HS_RARR;
						else if (dirty_r && op_code == bfc_pkg::OP_READ)
							st_r <= HS_RARR;
						else
							st_r <= HS_READ;
					end
				end
				HS_CMD1: begin
					if (cyc.done) begin
						if (op_r == bfc_pkg::OP_IDENTIFY)
							st_r <= HS_RESP;
						else if (!supply_ok_r) begin
							// Second cycle withheld without supply; read array goes out instead
							err_r   <= 1'b1;
							issue_r <= 1'b1;
							st_r    <= HS_RARR;
						end else begin
							issue_r <= 1'b1;
							st_r    <= HS_CMD2;
						end
					end
				end
				HS_CMD2: begin
					if (cyc.done)
						st_r <= HS_RESP;
				end
				HS_RARR: begin
					if (cyc.done) begin
						if (op_r == bfc_pkg::OP_READ) begin
							issue_r <= 1'b1;
							st_r    <= HS_READ;
						end else
							st_r <= HS_RESP;
					end
				end
				HS_READ: begin
					if (cyc.done)
						st_r <= HS_RESP;
				end
				HS_RESP: st_r <= HS_IDLE;
				default: st_r <= HS_IDLE;
			endcase
		end
	end

	// Array contents are stale after program or erase until read array goes out with no error pending
	always_ff @(posedge mclk) begin
		if (!nrst)
			dirty_r <= 1'b0;
		else if (st_r == HS_CMD1 && cyc.done && op_r != bfc_pkg::OP_IDENTIFY)
			dirty_r <= 1'b1;
		else if (st_r == HS_RARR && cyc.done && !err_r)
			dirty_r <= 1'b0;
	end

	// Read data latched from the engine when a read cycle ends
	always_ff @(posedge mclk) begin
		if (!nrst)
			rdata_r <= 16'h0000;
		else if (st_r == HS_READ && cyc.done)
			rdata_r <= byte_mode ? {8'h00, cyc.rdata[7:0]} : cyc.rdata;
	end

	// Cycle request contents for the engine
	always_comb begin
		cyc.req   = issue_r;
		cyc.addr  = addr_r;
		cyc.wr    = 1'b1;
		cyc.wdata = {8'h00, bfc_pkg::CMD_READ_ARRAY};
		case (st_r)
			HS_CMD1: begin
				if (op_r == bfc_pkg::OP_ERASE)
					cyc.wdata = {8'h00, bfc_pkg::CMD_ERASE_SETUP};
				else if (op_r == bfc_pkg::OP_PROGRAM)
					cyc.wdata = {8'h00, bfc_pkg::CMD_WRITE_SETUP};
				else
					cyc.wdata = {8'h00, bfc_pkg::CMD_IDENTIFY};
			end
			HS_CMD2: begin
				cyc.wdata = (op_r == bfc_pkg::OP_ERASE) ? {8'h00, bfc_pkg::CMD_ERASE_CONFIRM} : wdata_r;
			end
			HS_READ: cyc.wr = 1'b0;
			default: cyc.wr = 1'b1;
		endcase
	end

	// Supply and unlock are held over both cycles of a program or erase
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			program_supply_en     <= 1'b0;
			boot_unlock           <= 1'b0;
			identify_high_voltage <= 1'b0;
		end else begin
			program_supply_en     <= (st_r == HS_CMD1 || st_r == HS_CMD2) && op_r != bfc_pkg::OP_IDENTIFY;
			boot_unlock           <= (st_r == HS_CMD1 || st_r == HS_CMD2) && boot_r;
			identify_high_voltage <= 1'b0;
		end
	end

	// User side outputs
	assign op_ready  = (st_r == HS_IDLE);
	assign rsp_valid = (st_r == HS_RESP);
	assign rsp_rdata = rdata_r;
	assign rsp_err   = err_r;
	assign byte_n    = !byte_mode;
endmodule

/* File: bfc_pkg.sv */
// Package of constants for the boot flash bus controller
package bfc_pkg;
	// Command codes placed on the low byte lanes
	localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_WRITE_SETUP   = 8'h40;
	localparam logic [7:0] CMD_WRITE_SETUP2  = 8'h10;
	localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
	localparam logic [7:0] CMD_IDENTIFY      = 8'h90;
	// Bus widths
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	// Strobe phase timing in ns and cycles at 250 MHz (least times round up)
	localparam int CLK_PERIOD_NS  = 4;
	localparam int SETUP_NS       = 20;
	localparam int STROBE_NS      = 60;
	localparam int READ_ACCESS_NS = 100;
	localparam int HOLD_NS        = 20;
	localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC   = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W      = 8;
	// Operation codes on the user port
	localparam logic [2:0] OP_READ     = 3'h0;
	localparam logic [2:0] OP_PROGRAM  = 3'h1;
	localparam logic [2:0] OP_ERASE    = 3'h2;
	localparam logic [2:0] OP_READ_ARR = 3'h3;
	localparam logic [2:0] OP_IDENTIFY = 3'h4;
	localparam logic [2:0] OP_ID_READ  = 3'h5;
	// Identification addresses
	localparam logic [17:0] ID_MAKER_ADDR  = 18'h00000;
	localparam logic [17:0] ID_DEVICE_ADDR = 18'h00002;
endpackage

/* File: bfc_cyc_if.sv */
// Interface carrying one bus cycle between the sequencer and the pin engine
`timescale 1ns/100ps
interface bfc_cyc_if;
	logic        req;
	logic        wr;
	logic [17:0] addr;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rdata;
	modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
	modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* File: bfc_cycle_engine.sv */
// Pin engine that runs one asynchronous read or write cycle on the flash pins
`timescale 1ns/100ps
module bfc_cycle_engine (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Cycle request
	bfc_cyc_if.eng           cyc,
	// Byte mode select
	input  wire logic        byte_mode,
	// Flash pins
	output logic             ce_n,
	output logic             oe_n,
	output logic             we_n,
	output logic [16:0]      addr_o,
	output logic [15:0]      dq_o,
	output logic [15:0]      dq_oe,
	input  wire logic [15:0] dq_i
);
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_SETUP = 5'b00010,
		ST_STRB  = 5'b00100,
		ST_HOLD  = 5'b01000,
		ST_DONE  = 5'b10000
	} bfc_eng_e;

	bfc_eng_e                 st_r;
	logic [bfc_pkg::CNT_W-1:0] cnt_r;
	logic                     wr_r;
	logic [15:0]              q1_r;
	logic [15:0]              q2_r;
	logic [15:0]              q3_r;
	logic [15:0]              rdata_r;

	// Three-stage input sampling of the data pins
	always_ff @(posedge mclk) begin
		q1_r <= dq_i;
		q2_r <= q1_r;
		q3_r <= q2_r;
	end

	// Strobe sequencer; address and data stay put past the strobe rise
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_r  <= ST_IDLE;
			cnt_r <= 8'h00;
			wr_r  <= 1'b0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					if (cyc.req) begin
						wr_r  <= cyc.wr;
						cnt_r <= 8'(bfc_pkg::SETUP_CYC);
						st_r  <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					if (cnt_r <= 8'h01) begin
						cnt_r <= wr_r ? 8'(bfc_pkg::STROBE_CYC) : 8'(bfc_pkg::READ_CYC + 2);
						st_r  <= ST_STRB;
					end else
						cnt_r <= cnt_r - 8'h01;
				end
				ST_STRB: begin
					if (cnt_r <= 8'h01) begin
						cnt_r <= 8'(bfc_pkg::HOLD_CYC);
						st_r  <= ST_HOLD;
					end else
						cnt_r <= cnt_r - 8'h01;
				end
				ST_HOLD: begin
					if (cnt_r <= 8'h01)
						st_r <= ST_DONE;
					else
						cnt_r <= cnt_r - 8'h01;
				end
				ST_DONE: st_r <= ST_IDLE;
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// Read data captured at the end of the strobe; a lane changes only once its last two stages agree
	// Floating lanes in byte mode may never agree; they keep their old value and are masked upstream
	always_ff @(posedge mclk) begin
		if (!nrst)
			rdata_r <= 16'h0000;
		else if (st_r == ST_STRB && cnt_r == 8'h01 && !wr_r)
			rdata_r <= (q3_r & ~(q2_r ^ q3_r)) | (rdata_r & (q2_r ^ q3_r));
	end

	// Pin outputs; write strobe rises before address and data change
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ce_n   <= 1'b1;
			oe_n   <= 1'b1;
			we_n   <= 1'b1;
			addr_o <= 17'h00000;
			dq_o   <= 16'h0000;
			dq_oe  <= 16'h0000;
		end else begin
			if (st_r == ST_IDLE && cyc.req) begin
				addr_o <= cyc.addr[17:1];
				ce_n   <= 1'b0;
				if (cyc.wr) begin
					// Commands and byte data use low lanes; pin 15 carries A-1 in byte mode
					dq_o  <= byte_mode ? {cyc.addr[0], 7'h00, cyc.wdata[7:0]} : cyc.wdata;
					dq_oe <= byte_mode ? 16'h80FF : 16'hFFFF;
				end else begin
					dq_o  <= {cyc.addr[0], 15'h0000};
					dq_oe <= byte_mode ? 16'h8000 : 16'h0000;
				end
			end
			we_n <= !(st_r == ST_STRB && wr_r) && !(st_r == ST_SETUP && cnt_r <= 8'h01 && wr_r);
			oe_n <= !(st_r == ST_STRB && !wr_r) && !(st_r == ST_SETUP && cnt_r <= 8'h01 && !wr_r);
			if (st_r == ST_DONE) begin
				ce_n  <= 1'b1;
				dq_oe <= 16'h0000;
			end
		end
	end

	assign cyc.done  = (st_r == ST_DONE);
	assign cyc.rdata = rdata_r;
endmodule

/* File: bfc_flash_model.sv */
// Behavioural boot flash device facing the host controller
`timescale 1ns/100ps
module bfc_flash_model #(
	parameter logic [15:0] MAKER_CODE = 16'h1E5A, // Arbitrary value
	parameter logic [15:0] DEV_CODE   = 16'h3CA2  // Arbitrary value, bottom boot
) (
	// Timebase for the float pattern only
	input  wire logic        mclk,
	// Control pins
	input  wire logic        reset_powerdown_n,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        byte_n,
	input  wire logic        vpp_ok,
	input  wire logic        boot_unlock,
	input  wire logic [16:0] addr,
	// Host side of the data lines
	input  wire logic [15:0] host_q,
	input  wire logic [15:0] host_oe,
	// Resolved data lines
	output logic [15:0]      bus
);
	typedef enum logic [2:0] {ARR, ID, PSET, ESET, STAT} bfc_st_e;
	bfc_st_e     st;
	logic [15:0] mem [0:15];
	logic [15:0] q;
	logic [15:0] f_oe;
	logic        tgl = 1'b0;
	logic        wstb;
	logic        en;
	logic [3:0]  ix;
	assign ix = {addr[16], addr[2:0]};
	assign wstb = we_n | ce_n;
	// Low half of the map is the protected boot block
	assign en = vpp_ok && (addr[16] || boot_unlock);
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	// Commands land when the strobe pair ends the cycle
	always @(posedge wstb or negedge reset_powerdown_n) begin
		if (!reset_powerdown_n) st <= ARR;
		else case (st)
			PSET: begin
				if (en && byte_n) mem[ix] <= host_q;
				else if (en && host_q[15]) mem[ix][15:8] <= host_q[7:0];
				else if (en) mem[ix][7:0] <= host_q[7:0];
				st <= STAT;
			end
			ESET: begin
				if (en && host_q[7:0] == 8'hD0) foreach (mem[i]) if (i[3] == addr[16]) mem[i] <= 16'hFFFF;
				st <= STAT;
			end
			default: case (host_q[7:0])
				8'h20: st <= ESET;
				8'h10, 8'h40: st <= PSET;
				8'h90: st <= ID;
				8'hFF: st <= ARR;
				default: st <= st;
			endcase
		endcase
	end
	// Read data; status shows until read array is written
	always_comb begin
		q = st == ID ? (addr[0] ? DEV_CODE : MAKER_CODE) : st == STAT ? 16'h0080 : mem[ix];
		if (!byte_n && st != ID && host_q[15]) q = {8'h00, q[15:8]};
		f_oe = (!reset_powerdown_n || ce_n || oe_n || !we_n) ? 16'h0000 : byte_n ? 16'hFFFF : 16'h00FF;
	end
	always @(posedge mclk) tgl <= !tgl;
	// Released lanes toggle so a stale value never looks valid
	always_comb for (int i = 0; i < 16; i++) bus[i] = host_oe[i] ? host_q[i] : f_oe[i] ? q[i] : tgl ^ i[0];
endmodule

/* File: bfc_host_properties.sv */
// Pin protocol checks for the boot flash host controller
`timescale 1ns/100ps
module bfc_host_properties (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	// Flash pins and mode
	input wire logic        reset_powerdown_n,
	input wire logic        ce_n,
	input wire logic        oe_n,
	input wire logic        we_n,
	input wire logic        byte_n,
	input wire logic        byte_mode,
	input wire logic [16:0] addr_o,
	input wire logic [15:0] dq_o,
	input wire logic [15:0] dq_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Write strobe stays low for at least 8 cycles after it falls
	sequence s_strobe;
		!we_n [*8];
	endsequence
	a_reset_parks_pins: assert property (disable iff (1'b0) !nrst |=> !reset_powerdown_n && ce_n && dq_oe == 16'h0000)
		else $error("pins not parked in reset");
	a_idle_no_drive: assert property (ce_n |-> dq_oe == 16'h0000)
		else $error("host drives while deselected");
	a_read_no_drive: assert property (!oe_n |-> dq_oe == (byte_mode ? 16'h8000 : 16'h0000) && we_n && !ce_n)
		else $error("host drives during read");
	a_cmd_pins: assert property (!we_n |-> !ce_n && oe_n && reset_powerdown_n)
		else $error("bad write cycle pins");
	a_byte_lanes: assert property (byte_mode && !we_n |-> dq_oe[14:8] == 7'h00 && !byte_n)
		else $error("middle lanes driven in byte mode");
	a_we_first: assert property ($rose(we_n) |-> !ce_n)
		else $error("chip select rose before write strobe");
	a_strobe_width: assert property ($fell(we_n) |-> s_strobe)
		else $error("write strobe too short");
	a_data_stable: assert property (!we_n && !$past(we_n) |-> $stable(dq_o) && $stable(addr_o))
		else $error("data moved under write strobe");
endmodule

/* File: bfc_host_tb.sv */
// Self-checking bench for the boot flash host controller
`timescale 1ns/100ps
module bfc_host_tb;
	logic        mclk, nrst, op_valid, op_ready, op_boot, byte_mode, rsp_valid, rsp_err, er;
	logic        program_supply_level, program_supply_en, boot_unlock, identify_high_voltage, supply_ok;
	logic        reset_powerdown_n, ce_n, oe_n, we_n, byte_n;
	logic [2:0]  op_code;
	logic [17:0] op_addr;
	logic [15:0] op_wdata, rsp_rdata, dq_o, dq_oe, dq_i, rd;
	logic [16:0] addr_o;
	int          mismatches = 0;
	int          num_checks = 0;
	bfc_host DUT (.mclk, .nrst, .op_valid, .op_ready, .op_code, .op_addr, .op_wdata, .op_boot, .byte_mode,
		.rsp_valid, .rsp_rdata, .rsp_err, .program_supply_level, .program_supply_en, .boot_unlock,
		.identify_high_voltage, .reset_powerdown_n, .ce_n, .oe_n, .we_n, .byte_n, .addr_o, .dq_o, .dq_oe, .dq_i);
	bfc_flash_model flash (.mclk, .reset_powerdown_n, .ce_n, .oe_n, .we_n, .byte_n, .vpp_ok(program_supply_level),
		.boot_unlock, .addr(addr_o), .host_q(dq_o), .host_oe(dq_oe), .bus(dq_i));
	// Supply reports good only once the host switches it on
	assign program_supply_level = program_supply_en & supply_ok;
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One user request, waits for the answer pulse
	task automatic do_op(input logic [2:0] c, input logic [17:0] a, input logic [15:0] d, input logic b);
		int n;
		op_code = c;
		op_addr = a;
		op_wdata = d;
		op_boot = b;
		op_valid = 1'b1;
		n = 0;
		while (op_ready !== 1'b1 && n < 500) begin
			@(posedge mclk);
			#1;
			n++;
		end
		@(posedge mclk);
		#1;
		op_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 1000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (rsp_valid !== 1'b1) mismatches++;
		rd = rsp_rdata;
		er = rsp_err;
	endtask
	task automatic t_program;
		do_op(bfc_pkg::OP_PROGRAM, 18'h20000, 16'hA55A, 1'b0);
		do_op(bfc_pkg::OP_PROGRAM, 18'h20002, 16'h0F0F, 1'b0);
		do_op(bfc_pkg::OP_READ, 18'h20000, 16'h0000, 1'b0);
		check(rd, 16'hA55A);
		do_op(bfc_pkg::OP_READ, 18'h20002, 16'h0000, 1'b0);
		check(rd, 16'h0F0F);
	endtask
	task automatic t_boot;
		do_op(bfc_pkg::OP_PROGRAM, 18'h00002, 16'h1234, 1'b0);
		do_op(bfc_pkg::OP_READ, 18'h00002, 16'h0000, 1'b0);
		check(rd, 16'hFFFF);
		do_op(bfc_pkg::OP_PROGRAM, 18'h00002, 16'h1234, 1'b1);
		do_op(bfc_pkg::OP_READ, 18'h00002, 16'h0000, 1'b0);
		check(rd, 16'h1234);
	endtask
	task automatic t_erase;
		supply_ok = 1'b0;
		do_op(bfc_pkg::OP_ERASE, 18'h20000, 16'h0000, 1'b0);
		check({15'h0000, er}, 16'h0001);
		do_op(bfc_pkg::OP_READ, 18'h20000, 16'h0000, 1'b0);
		check(rd, 16'hA55A);
		supply_ok = 1'b1;
		do_op(bfc_pkg::OP_ERASE, 18'h20000, 16'h0000, 1'b0);
		check({15'h0000, er}, 16'h0000);
		do_op(bfc_pkg::OP_READ, 18'h20002, 16'h0000, 1'b0);
		check(rd, 16'hFFFF);
		do_op(bfc_pkg::OP_READ, 18'h00002, 16'h0000, 1'b0);
		check(rd, 16'h1234);
	endtask
	task automatic t_ident;
		do_op(bfc_pkg::OP_IDENTIFY, 18'h00000, 16'h0000, 1'b0);
		do_op(bfc_pkg::OP_ID_READ, bfc_pkg::ID_MAKER_ADDR, 16'h0000, 1'b0);
		check(rd, 16'h1E5A);
		do_op(bfc_pkg::OP_ID_READ, 18'h00002, 16'h0000, 1'b0);
		check(rd, 16'h3CA2);
		byte_mode = 1'b1;
		do_op(bfc_pkg::OP_ID_READ, 18'h00002, 16'h0000, 1'b0);
		check(rd, 16'h00A2);
		do_op(bfc_pkg::OP_READ_ARR, 18'h00000, 16'h0000, 1'b0);
	endtask
	task automatic t_byte;
		do_op(bfc_pkg::OP_PROGRAM, 18'h20007, 16'h00C3, 1'b0);
		do_op(bfc_pkg::OP_READ, 18'h20007, 16'h0000, 1'b0);
		check(rd, 16'h00C3);
		do_op(bfc_pkg::OP_READ, 18'h20006, 16'h0000, 1'b0);
		check(rd, 16'h00FF);
		byte_mode = 1'b0;
		do_op(bfc_pkg::OP_READ, 18'h20006, 16'h0000, 1'b0);
		check(rd, 16'hC3FF);
	endtask
	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		{nrst, op_valid, op_boot, byte_mode, op_code, op_addr, op_wdata} = '0;
		supply_ok = 1'b1;
		repeat (10) @(posedge mclk);
		#1;
		check({13'h0000, ce_n, reset_powerdown_n, oe_n}, 16'h0005);
		check(dq_oe, 16'h0000);
		nrst = 1'b1;
		t_program;
		t_boot;
		t_erase;
		t_ident;
		t_byte;
		check({15'h0000, identify_high_voltage}, 16'h0000);
		finish_test;
	end
	// Watchdog well beyond the expected run
	initial begin
		#100000;
		mismatches++;
		finish_test;
	end
endmodule
bind bfc_host bfc_host_properties chk (.mclk, .nrst, .reset_powerdown_n, .ce_n, .oe_n, .we_n, .byte_n,
	.byte_mode, .addr_o, .dq_o, .dq_oe);
